// ---- eeprom_map.svh ----
// constant map and functional notes for the serial eeprom slave
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
// ==========================================================
// Functional notes
// [R1] protected page write still acks start, address word and memory address with 0
// [R2] protected write: first data byte gets no ack, array left untouched
// [R3] poll is start plus write-mode address word during the write cycle
// [R4] polling: no ack while write cycle runs, ack 0 once it is done
// [R5] every read starts with start and an address word with rw bit 1
// [R6] address counter holds last accessed address plus one; current read uses it
// [R7] read-mode address word acked 0, then byte sent msb first
// [R8] master no ack then stop ends the read, back to standby
// [R9] read of last address wraps the counter to zero
// [R10] write at last page address wraps to page start, page bits kept
// [R11] counter undefined after power-up; master sets it by a random read
// [R12] dummy write loads the address, acked 0, repeated start begins the read
// [R13] random read outputs the byte at the dummy-write address
// [R14] sequential read goes on while the master keeps acking
// [R15] master ack 0 increments address and sends next byte, no new start
// [R16] sequential read wraps from last address to zero and continues
// [R17] sequential read ends on master no ack then stop
// [R18] power-on guard blocks bus activity until lines are settled
// [R19] master keeps lines static during supply ramps
// [R20] pulses narrower than 50 ns on clock and data are ignored
// [R21] address word: type code, two strap bits, address msb, rw bit
// [R22] up to 16 bytes per page, only low four address bits step and wrap
// [R23] stop after data starts the timed write; bus ignored until it ends
// [R24] ninth clock carries the ack, receiver drives zero, sender releases
// [R25] nine-bit counter: msb from write-mode address word, low byte from memory address
// [R26] no ack and no stop after a read byte: release the line and wait
// ==========================================================
// timing
`define CLK_PERIOD_NS 50
`define WRITE_CYCLE_NS 5000000
`define WRITE_CYCLE_COUNT ((`WRITE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GLITCH_NS 50
`define GLITCH_COUNT 2'(((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define POR_COUNT 5'h10
// ==========================================================
// address word fields and frame positions
`define RW_POS 0
`define MSB_POS 1
`define STRAP_LO_POS 2
`define STRAP_HI_POS 3
`define TYPE_LSB 4
`define TYPE_MSB 7
`define BYTE_DONE 4'h8
`define ACK_DONE 4'h9
`define ADDR_RESET 9'h000
`endif

// ---- eeprom_pkg.sv ----
// types shared by the serial eeprom slave
package eeprom_pkg;
	typedef enum logic [2:0] {st_idle, st_dev, st_mem, st_wdata, st_read, st_wait} bus_state_t;
	typedef logic [8:0] mem_addr_t;
	typedef logic [7:0] byte_t;
endpackage : eeprom_pkg

// ---- i2c_master_model.sv ----
// behavioural two-wire bus master that drives the eeprom slave
`timescale 1ns/1ps
module i2c_master_model #(
	// 400 ns bit: the slave answers about 250 ns after a falling clock, so low must outlast it
	parameter int T_LOW = 300,
	parameter int T_HIGH = 100
) (
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	bit glitch = 1'b0;
	// lines stay released and static until the first start
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// ==========================================================
	// bus conditions
	task automatic start();
		sda_drv = 1'b1;
		// a full low phase lets a slave ack finish releasing before the clock rises
		#(T_LOW);
		scl = 1'b1;
		#(T_HIGH);
		sda_drv = 1'b0;
		#(T_HIGH);
		scl = 1'b0;
		#(T_LOW / 2);
	endtask : start
	task automatic stop();
		sda_drv = 1'b0;
		#(T_LOW);
		scl = 1'b1;
		#(T_HIGH);
		sda_drv = 1'b1;
		#(T_HIGH);
	endtask : stop
	// ==========================================================
	// bits and bytes
	// the optional 25 ns clock spike sits mid-low, away from any data change
	task automatic bit_x(input logic b, output logic r);
		sda_drv = b;
		// spike straddles one core clock edge so the filter really sees it
		#(T_LOW / 2 - 10);
		scl = glitch;
		#25;
		scl = 1'b0;
		#(T_LOW / 2 - 15);
		scl = 1'b1;
		#(T_HIGH / 2);
		r = sda_line;
		#(T_HIGH / 2);
		scl = 1'b0;
	endtask : bit_x
	// sender releases the line on the ninth clock; mack 0 keeps a read going
	task automatic byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
		output logic sack);
		for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
		bit_x(mack, sack);
	endtask : byte_x
endmodule : i2c_master_model

// ---- serial_eeprom_read_protect_poll.sv ----
// two-wire eeprom slave: protect, ack polling, reads and input filtering
`timescale 1ns/1ps
`include "eeprom_map.svh"
module serial_eeprom_read_protect_poll
	import eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES = `WRITE_CYCLE_COUNT,
	// arbitrary device type code
	parameter logic [3:0] DEVICE_TYPE_CODE = 4'h5
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic write_protect,
	input wire logic chip_select_strap_hi,
	input wire logic chip_select_strap_lo,
	output logic write_busy
);
	// ==========================================================
	// input synchronisers
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] wp_sync;
	logic [1:0] hi_sync;
	logic [1:0] lo_sync;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			wp_sync <= 2'h0;
			hi_sync <= 2'h0;
			lo_sync <= 2'h0;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			wp_sync <= {wp_sync[0], write_protect};
			hi_sync <= {hi_sync[0], chip_select_strap_hi};
			lo_sync <= {lo_sync[0], chip_select_strap_lo};
		end
	end
	logic scl_s;
	logic sda_s;
	logic wp_s;
	assign scl_s = scl_sync[1];
	assign sda_s = sda_sync[1];
	assign wp_s = wp_sync[1];

	// ==========================================================
	// glitch filter: a new level must persist past the suppression time
	function automatic logic [2:0] filt_step(input logic raw, input logic filt,
		input logic [1:0] cnt);
		if (raw == filt)
			return {filt, 2'h0};
		if (cnt == `GLITCH_COUNT)
			return {raw, 2'h0};
		return {filt, 2'(cnt + 2'h1)};
	endfunction : filt_step

	logic scl_f;
	logic sda_f;
	logic [1:0] scl_cnt;
	logic [1:0] sda_cnt;
	logic scl_d;
	logic sda_d;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{scl_f, scl_cnt} <= 3'h4;
			{sda_f, sda_cnt} <= 3'h4;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			{scl_f, scl_cnt} <= filt_step(scl_s, scl_f, scl_cnt); // R20
			{sda_f, sda_cnt} <= filt_step(sda_s, sda_f, sda_cnt); // R20
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// ==========================================================
	// power-on guard
	logic [4:0] por_cnt;
	logic por_ready;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			por_cnt <= 5'h00;
			por_ready <= 1'b0;
		end else if (!por_ready) begin
			// any toggle restarts the wait so ramp noise cannot open the bus
			if (!(scl_f && sda_f))
				por_cnt <= 5'h00; // R18
			else if (por_cnt == 5'(`POR_COUNT - 5'h01))
				por_ready <= 1'b1; // R18
			else
				por_cnt <= 5'(por_cnt + 5'h01);
		end
	end

	// ==========================================================
	// bus events
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise = scl_f && !scl_d;
	assign scl_fall = !scl_f && scl_d;
	assign bus_start = por_ready && scl_f && scl_d && sda_d && !sda_f;
	assign bus_stop = por_ready && scl_f && scl_d && !sda_d && sda_f;

	bus_state_t state;
	logic [3:0] bit_cnt;
	byte_t rx;
	byte_t tx;
	mem_addr_t addr_ptr;
	logic read_mode;
	logic wrote;
	logic master_ack;
	logic [16:0] busy_cnt;
	byte_t mem_array [512];

	logic byte_end;
	logic ack_end;
	logic dev_match;
	logic mem_we;
	logic rd_load;
	logic write_start;
	byte_t rd_byte;
	assign byte_end = scl_fall && bit_cnt == `BYTE_DONE;
	assign ack_end = scl_fall && bit_cnt == `ACK_DONE;
	assign dev_match = rx[`TYPE_MSB:`TYPE_LSB] == DEVICE_TYPE_CODE && // R21
		rx[`STRAP_HI_POS] == hi_sync[1] && rx[`STRAP_LO_POS] == lo_sync[1];
	assign mem_we = byte_end && state == st_wdata && !wp_s; // R2
	assign rd_load = ack_end && ((state == st_dev && read_mode) || // R7
		(state == st_read && master_ack)); // R15
	assign write_start = bus_stop && state == st_wdata && wrote && !write_busy; // R23
	assign rd_byte = mem_array[addr_ptr];

	// ==========================================================
	// bit framing: eight data clocks then the ack clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 4'h0;
			rx <= 8'h00;
			master_ack <= 1'b0;
		end else if (bus_start) begin
			bit_cnt <= 4'h0;
		end else begin
			if (scl_rise && bit_cnt != `ACK_DONE)
				bit_cnt <= 4'(bit_cnt + 4'h1);
			else if (ack_end)
				bit_cnt <= 4'h0; // R24
			if (scl_rise && bit_cnt < `BYTE_DONE)
				rx <= {rx[6:0], sda_f};
			if (scl_rise && bit_cnt == `BYTE_DONE && state == st_read)
				master_ack <= !sda_f; // R14
		end
	end

	// ==========================================================
	// protocol state
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= st_idle;
			read_mode <= 1'b0;
			wrote <= 1'b0;
		end else if (bus_start) begin
			state <= st_dev; // R3
			wrote <= 1'b0;
		end else if (bus_stop) begin
			state <= st_idle; // R8 R17
		end else if (byte_end) begin
			unique case (state)
				st_dev: begin
					read_mode <= rx[`RW_POS]; // R5
					if (!dev_match || write_busy)
						state <= st_wait; // R4
				end
				st_wdata: begin
					if (wp_s)
						state <= st_wait; // R2
					else
						wrote <= 1'b1;
				end
				st_idle, st_mem, st_read, st_wait: begin
				end
			endcase
		end else if (ack_end) begin
			unique case (state)
				st_dev: state <= read_mode ? st_read : st_mem; // R12
				st_mem: state <= st_wdata;
				st_read: state <= master_ack ? st_read : st_wait; // R26
				st_idle, st_wdata, st_wait: begin
				end
			endcase
		end
	end

	// ==========================================================
	// address counter
	function automatic mem_addr_t page_next(input mem_addr_t a);
		return {a[8:4], 4'(a[3:0] + 4'h1)};
	endfunction : page_next

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_ptr <= `ADDR_RESET; // R11
		end else if (byte_end && state == st_dev && dev_match && !write_busy &&
			!rx[`RW_POS]) begin
			addr_ptr[8] <= rx[`MSB_POS]; // R25
		end else if (byte_end && state == st_mem) begin
			addr_ptr[7:0] <= rx; // R12 R25
		end else if (mem_we) begin
			addr_ptr <= page_next(addr_ptr); // R10 R22
		end else if (rd_load) begin
			// nine-bit carry rolls the last address over to zero
			addr_ptr <= 9'(addr_ptr + 9'h001); // R6 R9 R16
		end
	end

	// array has no reset; its contents are whatever was last written
	always_ff @(posedge core_clk) begin
		if (mem_we)
			mem_array[addr_ptr] <= rx; // R22
	end

	// ==========================================================
	// data line drive, changed only while the clock is low
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			tx <= 8'h00;
		end else if (bus_start || bus_stop) begin
			sda_oe <= 1'b0;
		end else if (byte_end) begin
			unique case (state)
				st_dev: sda_oe <= dev_match && !write_busy; // R1 R4 R7
				st_mem: sda_oe <= 1'b1; // R1 R12
				st_wdata: sda_oe <= !wp_s; // R2
				st_idle, st_read, st_wait: sda_oe <= 1'b0; // R24
			endcase
		end else if (ack_end) begin
			if (rd_load) begin
				tx <= rd_byte; // R13
				sda_oe <= !rd_byte[7]; // R7
			end else begin
				sda_oe <= 1'b0; // R26
			end
		end else if (scl_fall && state == st_read && bit_cnt != 4'h0) begin
			sda_oe <= !tx[6]; // R7
			tx <= {tx[6:0], 1'b0};
		end
	end

	// ==========================================================
	// internally timed write cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			write_busy <= 1'b0;
			busy_cnt <= 17'h00000;
		end else if (write_start) begin
			write_busy <= 1'b1; // R3 R23
			busy_cnt <= 17'h00000;
		end else if (write_busy) begin
			if (busy_cnt == 17'(WRITE_CYCLES - 1))
				write_busy <= 1'b0; // R4
			else
				busy_cnt <= 17'(busy_cnt + 17'h00001);
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	property p_poll_nack;
		write_busy && $past(write_busy) |-> !sda_oe;
	endproperty
	a_poll_nack: assert property (p_poll_nack) else $error("drove sda in write cycle"); // R4

	property p_protect_nack;
		byte_end && state == st_wdata && wp_s |=> state == st_wait && !sda_oe ##1 !sda_oe;
	endproperty
	a_protect_nack: assert property (p_protect_nack) else $error("protected data acked"); // R2

	property p_mem_ack;
		byte_end && state == st_mem |=> sda_oe && state == st_mem;
	endproperty
	a_mem_ack: assert property (p_mem_ack) else $error("memory address not acked"); // R1

	property p_page_wrap;
		mem_we && addr_ptr[3:0] == 4'hF |=> addr_ptr == {$past(addr_ptr[8:4]), 4'h0};
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page wrap wrong"); // R10

	property p_read_wrap;
		rd_load && addr_ptr == 9'h1FF |=> addr_ptr == 9'h000 && state == st_read;
	endproperty
	a_read_wrap: assert property (p_read_wrap) else $error("read wrap wrong"); // R9

	property p_read_next;
		rd_load |=> tx == $past(rd_byte) && sda_oe == !tx[7];
	endproperty
	a_read_next: assert property (p_read_next) else $error("read byte not driven"); // R15

	property p_stop_idle;
		bus_stop |=> state == st_idle && !sda_oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle"); // R8

	property p_write_start;
		write_start |=> write_busy [*8];
	endproperty
	a_write_start: assert property (p_write_start) else $error("write cycle not held"); // R23

	property p_glitch;
		$changed(scl_f) |-> $past(scl_s) == scl_f && $past(scl_s, 2) == scl_f;
	endproperty
	a_glitch: assert property (p_glitch) else $error("short scl pulse passed"); // R20

	property p_por;
		!por_ready |-> state == st_idle && !sda_oe;
	endproperty
	a_por: assert property (p_por) else $error("bus active before power-on guard"); // R18

	property p_dev_ack;
		byte_end && state == st_dev && dev_match && !write_busy |=> sda_oe;
	endproperty
	a_dev_ack: assert property (p_dev_ack) else $error("address word not acked"); // R7

	property p_strap_nack;
		byte_end && state == st_dev && !dev_match |=> state == st_wait && !sda_oe;
	endproperty
	a_strap_nack: assert property (p_strap_nack) else $error("foreign address word acked"); // R21

	c_read_wrap: cover property (rd_load && addr_ptr == 9'h1FF);
	c_poll: cover property (byte_end && state == st_dev && write_busy);
	c_seq_read: cover property (rd_load && state == st_read);
	c_protect: cover property (byte_end && state == st_wdata && wp_s);
	c_write: cover property (write_start);
endmodule : serial_eeprom_read_protect_poll

// ---- test_serial_eeprom_read_protect_poll.sv ----
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ps
module test_serial_eeprom_read_protect_poll import eeprom_pkg::*;;
	// arbitrary type code
	localparam logic [3:0] TYPE_CODE = 4'h9;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic write_protect = 1'b0;
	logic [1:0] straps = 2'h0;
	logic scl, sda_drv, sda_oe, sda_out, busy;
	wire logic sda = sda_drv & ~(sda_oe & ~sda_out);
	byte_t mem [512];
	bit known [512];
	mem_addr_t ctr = 9'h000;
	int fail_count = 0, checked = 0, seed = 70;
	serial_eeprom_read_protect_poll #(.WRITE_CYCLES(200), .DEVICE_TYPE_CODE(TYPE_CODE)) i_dut (
		.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
		.chip_select_strap_hi(straps[1]), .chip_select_strap_lo(straps[0]),
		.write_busy(busy));
	i2c_master_model i_master (.sda_line(sda), .scl(scl), .sda_drv(sda_drv));
	initial forever #25 core_clk = ~core_clk;
	// ==========================================================
	// helpers
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic pins(input logic wp);
		@(posedge core_clk);
		#2;
		write_protect = wp;
		straps = 2'($random(seed));
	endtask : pins
	function automatic byte_t dev(input logic msb, input logic rw);
		return {TYPE_CODE, straps, msb, rw};
	endfunction : dev
	task automatic wr(input mem_addr_t a, input int n, input logic wp);
		byte_t rx, d;
		logic ack;
		int k;
		pins(wp);
		i_master.start();
		i_master.byte_x(dev(a[8], 1'b0), 1'b1, rx, ack);
		chk("dev ack", 8'(ack), 8'h00);
		i_master.byte_x(a[7:0], 1'b1, rx, ack);
		chk("mem ack", 8'(ack), 8'h00);
		for (k = 0; k < n; k++) begin
			d = byte_t'($random(seed));
			i_master.byte_x(d, 1'b1, rx, ack);
			chk("data ack", 8'(ack), 8'(wp));
			if (!wp) begin
				mem[{a[8:4], a[3:0] + 4'(k)}] = d;
				known[{a[8:4], a[3:0] + 4'(k)}] = 1'b1;
			end
		end
		i_master.stop();
		if (wp)
			return;
		ctr = {a[8:4], a[3:0] + 4'(n)};
		repeat (6) @(posedge core_clk);
		#2;
		chk("busy", 8'(busy), 8'h01);
		k = 0;
		do begin
			i_master.start();
			i_master.byte_x(dev(ctr[8], 1'b0), 1'b1, rx, ack);
			if (k == 0)
				chk("poll busy", 8'(ack), 8'h01);
			k++;
		end while (ack && k < 10);
		chk("poll done", 8'(ack), 8'h00);
		i_master.stop();
	endtask : wr
	task automatic rd(input mem_addr_t a, input logic rnd, input int n);
		byte_t rx;
		logic ack;
		if (rnd) begin
			i_master.start();
			i_master.byte_x(dev(a[8], 1'b0), 1'b1, rx, ack);
			i_master.byte_x(a[7:0], 1'b1, rx, ack);
			chk("dummy ack", 8'(ack), 8'h00);
			ctr = a;
		end
		i_master.start();
		i_master.byte_x(dev(1'b0, 1'b1), 1'b1, rx, ack);
		chk("read ack", 8'(ack), 8'h00);
		for (int k = 1; k <= n; k++) begin
			i_master.byte_x(8'hFF, k == n, rx, ack);
			if (known[ctr])
				chk("read data", rx, mem[ctr]);
			ctr++;
		end
		// after a refused byte the line must stay released
		i_master.byte_x(8'hFF, 1'b1, rx, ack);
		chk("released", rx, 8'hFF);
		i_master.stop();
	endtask : rd
	// ==========================================================
	// main sequence
	initial begin
		byte_t srx;
		logic sack;
		repeat (3) @(posedge core_clk);
		#2;
		reset_n = 1'b1;
		repeat (30) @(posedge core_clk);
		wr(9'h1F8, 18, 1'b0);
		rd(9'h000, 1'b0, 3);
		wr(9'h000, 16, 1'b0);
		wr(9'h010, 16, 1'b0);
		wr(9'h00E, 2, 1'b0);
		rd(9'h000, 1'b0, 2);
		rd(9'h1FE, 1'b1, 4);
		rd(9'h1FF, 1'b1, 1);
		rd(9'h000, 1'b0, 1);
		wr(9'h005, 2, 1'b1);
		rd(9'h005, 1'b1, 2);
		pins(1'b0);
		i_master.start();
		i_master.byte_x({TYPE_CODE, ~straps, 2'h0}, 1'b1, srx, sack);
		chk("strap nack", 8'(sack), 8'h01);
		i_master.stop();
		i_master.glitch = 1'b1;
		wr(9'h020, 3, 1'b0);
		rd(9'h020, 1'b1, 3);
		i_master.glitch = 1'b0;
		end_sim();
	end
	initial begin
		#3000000;
		fail_count++;
		end_sim();
	end
endmodule : test_serial_eeprom_read_protect_poll
